// ==== rtl/dpc_cfg.svh ====
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// ****************************************************************
// parameter addresses (16-bit word addresses)
// ****************************************************************
`define DPC_ADDR_DONE_FLAGS  16'h0a02
`define DPC_ADDR_EDGE1       16'h0a04
`define DPC_ADDR_EDGE2       16'h0a06
`define DPC_ADDR_ARM1        16'h0a08
`define DPC_ADDR_ARM2        16'h0a0a
`define DPC_ADDR_POS1_HI     16'h0a0c
`define DPC_ADDR_POS1_LO     16'h0a0d
`define DPC_ADDR_POS2_HI     16'h0a0e
`define DPC_ADDR_POS2_LO     16'h0a0f
`define DPC_ADDR_COUNT1      16'h0a10
`define DPC_ADDR_COUNT2      16'h0a12

// ****************************************************************
// field encodings and reset values
// ****************************************************************
`define DPC_ARM_STOP         16'h0000
`define DPC_ARM_ONCE         16'h0001
`define DPC_ARM_CONT         16'h0002
`define DPC_EDGE_FALL        16'h0000
`define DPC_EDGE_RISE        16'h0001
`define DPC_EDGE_RESET       16'h0000
`define DPC_ARM_RESET        16'h0000
`define DPC_COUNT_RESET      16'h0000
`define DPC_POS_RESET        32'h0000_0000

`endif

// ==== rtl/dpc_pkg.sv ====
package dpc_pkg;

	// channel capture mode
	typedef enum logic [1:0] {
		DPC_IDLE,
		DPC_ONCE,
		DPC_CONT
	} dpc_mode_t;

	// decoded parameter address
	typedef enum logic [3:0] {
		DPC_R_NONE,
		DPC_R_DONE,
		DPC_R_EDGE,
		DPC_R_ARM,
		DPC_R_POS_HI,
		DPC_R_POS_LO,
		DPC_R_COUNT
	} dpc_reg_t;

endpackage

// ==== rtl/dpc_capture.sv ====
`timescale 1ns/1ps
`include "dpc_cfg.svh"

// What this block does
// [RULE1] activation value 0 cancels, 1 arms one capture, 2 arms repeated capture
// [RULE2] single-capture mode stops after the first latched position
// [RULE3] repeated mode stays armed and latches on every later edge until cancelled
// [RULE4] edge select 0 captures on falling edge, 1 on rising edge
// [RULE5] each channel keeps a 16-bit read-only count of capture events
// [RULE6] a channel's count clears whenever its activation field is written to arm
// [RULE7] each capture stores the signed 32-bit axis position at the edge
// [RULE8] position redefinition shifts stored captured positions into the new frame
// [RULE9] activation and edge-select writes act at once with no commit step
// [RULE10] two independent channels with their own fields at separate addresses
// [RULE11] shared status word: bit 0 channel one captured, bit 1 channel two captured
// [RULE12] channel two has its own cleared-on-arm count and 32-bit position
// [RULE13] capture inputs pass a two-stage synchroniser before edge detection
// [RULE14] after a single capture, edges are ignored and position holds until rearmed
module dpc_capture #(
	parameter int POS_W = 32,
	parameter int CNT_W = 16
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              capture_input_one,
	input  wire logic              capture_input_two,
	input  wire logic [POS_W-1:0]  axis_position,
	input  wire logic              position_redefine,
	input  wire logic [POS_W-1:0]  position_shift,
	input  wire logic [15:0]       par_addr,
	input  wire logic              par_wr,
	input  wire logic [15:0]       par_wdata,
	input  wire logic              par_rd,
	output logic      [15:0]       par_rdata,
	output logic                   par_ack,
	output logic                   par_err
);

	// ****************************************************************
	// address decode
	// ****************************************************************

	// maps a word address to a register kind and its channel
	function automatic dpc_pkg::dpc_reg_t dec_reg(input logic [15:0] a, output logic ch);
		ch = 1'b0;
		case (a)
			`DPC_ADDR_DONE_FLAGS: dec_reg = dpc_pkg::DPC_R_DONE;
			`DPC_ADDR_EDGE1:      dec_reg = dpc_pkg::DPC_R_EDGE;
			`DPC_ADDR_EDGE2: begin
				ch = 1'b1;
				dec_reg = dpc_pkg::DPC_R_EDGE;
			end
			`DPC_ADDR_ARM1:       dec_reg = dpc_pkg::DPC_R_ARM;
			`DPC_ADDR_ARM2: begin
				ch = 1'b1;
				dec_reg = dpc_pkg::DPC_R_ARM;
			end
			`DPC_ADDR_POS1_HI:    dec_reg = dpc_pkg::DPC_R_POS_HI;
			`DPC_ADDR_POS1_LO:    dec_reg = dpc_pkg::DPC_R_POS_LO;
			`DPC_ADDR_POS2_HI: begin
				ch = 1'b1;
				dec_reg = dpc_pkg::DPC_R_POS_HI;
			end
			`DPC_ADDR_POS2_LO: begin
				ch = 1'b1;
				dec_reg = dpc_pkg::DPC_R_POS_LO;
			end
			`DPC_ADDR_COUNT1:     dec_reg = dpc_pkg::DPC_R_COUNT;
			`DPC_ADDR_COUNT2: begin
				ch = 1'b1;
				dec_reg = dpc_pkg::DPC_R_COUNT;
			end
			default:              dec_reg = dpc_pkg::DPC_R_NONE;
		endcase
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************

	logic              [1:0]       in_s1_q, in_s2_q, in_s3_q;
	logic              [1:0]       in_s1_d, in_s2_d, in_s3_d;
	logic              [POS_W-1:0] pos_p1_q, pos_p2_q;
	dpc_pkg::dpc_mode_t            mode_q [2];
	dpc_pkg::dpc_mode_t            mode_d [2];
	logic              [15:0]      arm_q [2];
	logic              [15:0]      arm_d [2];
	logic              [15:0]      edge_q [2];
	logic              [15:0]      edge_d [2];
	logic              [CNT_W-1:0] cnt_q [2];
	logic              [CNT_W-1:0] cnt_d [2];
	logic              [POS_W-1:0] pos_q [2];
	logic              [POS_W-1:0] pos_d [2];
	logic              [1:0]       done_q, done_d;
	logic              [15:0]      rdata_d;
	logic                          ack_d, err_d;
	logic              [1:0]       cap_in;
	logic              [1:0]       hit;
	dpc_pkg::dpc_reg_t             acc_reg;
	logic                          acc_ch;

	assign cap_in = {capture_input_two, capture_input_one};

	// ****************************************************************
	// next-state logic
	// ****************************************************************

	// synchroniser, edge detect, mode, count, position and access
	always_comb begin
		acc_reg = dec_reg(par_addr, acc_ch);
		in_s1_d = cap_in;                              // [RULE13]
		in_s2_d = in_s1_q;                             // [RULE13]
		in_s3_d = in_s2_q;
		done_d  = done_q;
		rdata_d = par_rdata;
		ack_d   = par_rd | par_wr;
		err_d   = 1'b0;
		for (int c = 0; c < 2; c++) begin             // [RULE10] [RULE12]
			mode_d[c] = mode_q[c];
			arm_d[c]  = arm_q[c];
			edge_d[c] = edge_q[c];
			cnt_d[c]  = cnt_q[c];
			pos_d[c]  = pos_q[c];
			// edge on the synchronised level only
			hit[c] = (edge_q[c][0] ? (in_s2_q[c] & ~in_s3_q[c])
			                       : (~in_s2_q[c] & in_s3_q[c]))
			         && (mode_q[c] != dpc_pkg::DPC_IDLE); // [RULE4] [RULE14]
			if (position_redefine) begin
				pos_d[c] = pos_q[c] + position_shift;   // [RULE8]
			end
			if (hit[c]) begin
				pos_d[c] = pos_p2_q;                     // [RULE7]
				cnt_d[c] = cnt_q[c] + CNT_W'(1);         // [RULE5]
				if (mode_q[c] == dpc_pkg::DPC_ONCE) begin
					mode_d[c] = dpc_pkg::DPC_IDLE;        // [RULE2]
					arm_d[c]  = `DPC_ARM_STOP;
				end                                      // repeated mode stays armed [RULE3]
			end
		end
		// parameter write, effective on the next edge
		if (par_wr) begin
			case (acc_reg)
				dpc_pkg::DPC_R_EDGE: begin
					if (par_wdata == `DPC_EDGE_FALL || par_wdata == `DPC_EDGE_RISE) begin
						edge_d[acc_ch] = par_wdata;          // [RULE9]
					end else begin
						err_d = 1'b1;
					end
				end
				dpc_pkg::DPC_R_ARM: begin
					case (par_wdata)                     // [RULE1] [RULE9]
						`DPC_ARM_STOP: begin
							mode_d[acc_ch] = dpc_pkg::DPC_IDLE;
							arm_d[acc_ch]  = par_wdata;
						end
						`DPC_ARM_ONCE: begin
							mode_d[acc_ch] = dpc_pkg::DPC_ONCE;
							arm_d[acc_ch]  = par_wdata;
							cnt_d[acc_ch]  = `DPC_COUNT_RESET; // [RULE6]
							done_d[acc_ch] = hit[acc_ch];  // set wins over clear
						end
						`DPC_ARM_CONT: begin
							mode_d[acc_ch] = dpc_pkg::DPC_CONT;
							arm_d[acc_ch]  = par_wdata;
							cnt_d[acc_ch]  = `DPC_COUNT_RESET; // [RULE6]
							done_d[acc_ch] = hit[acc_ch];
						end
						default: err_d = 1'b1;
					endcase
				end
				default: err_d = 1'b1;                 // read-only or unmapped
			endcase
		end
		done_d = done_d | hit;                          // [RULE11]
		// parameter read, answered one cycle later
		if (par_rd) begin
			case (acc_reg)
				dpc_pkg::DPC_R_DONE:   rdata_d = {14'h0000, done_q}; // [RULE11]
				dpc_pkg::DPC_R_EDGE:   rdata_d = edge_q[acc_ch];
				dpc_pkg::DPC_R_ARM:    rdata_d = arm_q[acc_ch];
				dpc_pkg::DPC_R_POS_HI: rdata_d = pos_q[acc_ch][31:16];
				dpc_pkg::DPC_R_POS_LO: rdata_d = pos_q[acc_ch][15:0];
				dpc_pkg::DPC_R_COUNT:  rdata_d = cnt_q[acc_ch];
				default: begin
					rdata_d = 16'h0000;
					err_d   = 1'b1;
				end
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	// position delay matches the synchroniser latency
	always_ff @(posedge clk) begin
		pos_p1_q <= axis_position;
		pos_p2_q <= pos_p1_q;
		in_s1_q  <= in_s1_d;
		in_s2_q  <= in_s2_d;
		in_s3_q  <= in_s3_d;
		if (reset) begin
			done_q    <= 2'h0;
			par_rdata <= 16'h0000;
			par_ack   <= 1'b0;
			par_err   <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				mode_q[c] <= dpc_pkg::DPC_IDLE;
				arm_q[c]  <= `DPC_ARM_RESET;
				edge_q[c] <= `DPC_EDGE_RESET;
				cnt_q[c]  <= `DPC_COUNT_RESET;
				pos_q[c]  <= `DPC_POS_RESET;
			end
		end else begin
			done_q    <= done_d;
			par_rdata <= rdata_d;
			par_ack   <= ack_d;
			par_err   <= err_d;
			for (int c = 0; c < 2; c++) begin
				mode_q[c] <= mode_d[c];
				arm_q[c]  <= arm_d[c];
				edge_q[c] <= edge_d[c];
				cnt_q[c]  <= cnt_d[c];
				pos_q[c]  <= pos_d[c];
			end
		end
	end

endmodule

// ==== tb/dpc_src.sv ====
`timescale 1ns/1ps
// capture signal source: level flips one cycle after each flip request
module dpc_src (
	input  wire logic clk,
	input  wire logic flip,
	output logic      lvl
);
	initial lvl = 1'b0;
	// ****************
	// level register
	// ****************
	always @(posedge clk) begin
		if (flip) lvl <= ~lvl;
	end
endmodule

// ==== tb/dpc_capture_asserts.sv ====
`timescale 1ns/1ps
module dpc_capture_asserts #(
	parameter int POS_W = 32,
	parameter int CNT_W = 16
) (
	input wire logic             clk,
	input wire logic             reset,
	input wire logic             capture_input_one,
	input wire logic             capture_input_two,
	input wire logic [POS_W-1:0] axis_position,
	input wire logic             position_redefine,
	input wire logic [POS_W-1:0] position_shift,
	input wire logic [15:0]      par_addr,
	input wire logic             par_wr,
	input wire logic [15:0]      par_wdata,
	input wire logic             par_rd,
	input wire logic [15:0]      par_rdata,
	input wire logic             par_ack,
	input wire logic             par_err
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ****************
	// register port
	// ****************
	a_req_gets_ack: assert property ((par_wr || par_rd) |=> par_ack) else $error("no ack");
	a_ack_has_req: assert property (par_ack |-> $past(par_wr) || $past(par_rd)) else $error("stray ack");
	a_err_with_ack: assert property (par_err |-> par_ack) else $error("err without ack");
	a_bad_arm_err: assert property (par_wr && par_addr == 16'h0a08 && par_wdata > 16'h0002 |=> par_err)
		else $error("bad arm accepted");
	a_good_arm_ok: assert property (par_wr && par_addr == 16'h0a08 && par_wdata <= 16'h0002 |=> !par_err)
		else $error("arm refused");
	a_arm_two_ok: assert property (par_wr && par_addr == 16'h0a0a && par_wdata <= 16'h0002 |=> !par_err)
		else $error("arm2 refused");
	a_bad_edge_err: assert property (par_wr && par_addr == 16'h0a04 && par_wdata > 16'h0001 |=> par_err)
		else $error("bad edge accepted");
	a_pos_read_only: assert property (par_wr && par_addr == 16'h0a0c |=> par_err)
		else $error("pos written");
	a_cnt_read_only: assert property (par_wr && par_addr == 16'h0a10 |=> par_err)
		else $error("count written");
	a_flag_bits: assert property (par_rd && par_addr == 16'h0a02 |=> !par_err && par_rdata[15:2] == 0)
		else $error("flag word upper bits set");
	c_arm_cont: cover property (par_wr && par_addr == 16'h0a08 && par_wdata == 16'h0002);
	c_err: cover property (par_err);
	c_pos_rd: cover property (par_rd && par_addr == 16'h0a0c);
endmodule
bind dpc_capture dpc_capture_asserts #(.POS_W(POS_W), .CNT_W(CNT_W)) chk_u (.clk(clk), .reset(reset),
	.capture_input_one(capture_input_one), .capture_input_two(capture_input_two),
	.axis_position(axis_position), .position_redefine(position_redefine), .position_shift(position_shift),
	.par_addr(par_addr), .par_wr(par_wr), .par_wdata(par_wdata), .par_rd(par_rd), .par_rdata(par_rdata),
	.par_ack(par_ack), .par_err(par_err));

// ==== tb/dpc_capture_tb.sv ====
`timescale 1ns/1ps
module dpc_capture_tb;
	typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [15:0] q; logic e;} dpc_row_t;
	logic        clk = 0, reset = 1, t1 = 0, t2 = 0, redef = 0, wr = 0, rd = 0, c1, c2, ack, err, e;
	logic [31:0] axis = 0, shift = 0;
	logic [15:0] addr = 0, wdata = 0, rdata, q;
	int          failures = 0, n_checks = 0;
	dpc_row_t    rows [10] = '{'{0, 'ha04, 0, 0, 0}, '{0, 'ha08, 0, 0, 0}, '{0, 'ha10, 0, 0, 0},
		'{1, 'ha04, 1, 0, 0}, '{1, 'ha04, 2, 0, 1}, '{0, 'ha04, 0, 1, 0}, '{1, 'ha08, 3, 0, 1},
		'{1, 'ha10, 5, 0, 1}, '{1, 'ha0c, 5, 0, 1}, '{0, 'ha20, 0, 0, 1}};
	// clock
	always #10 clk = ~clk;
	dpc_src s1_u (.clk(clk), .flip(t1), .lvl(c1));
	dpc_src s2_u (.clk(clk), .flip(t2), .lvl(c2));
	dpc_capture dut_u (.clk(clk), .reset(reset), .capture_input_one(c1), .capture_input_two(c2),
		.axis_position(axis), .position_redefine(redef), .position_shift(shift), .par_addr(addr),
		.par_wr(wr), .par_wdata(wdata), .par_rd(rd), .par_rdata(rdata), .par_ack(ack), .par_err(err));
	// ****************
	// helpers
	// ****************
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		{wr, rd, addr, wdata} <= {w, !w, a, d};
		@(posedge clk);
		{wr, rd} <= 2'b00;
		#1;
		chk("ack", ack, 1);
		q = rdata;
		e = err;
	endtask
	task flip(input logic ch);
		@(posedge clk);
		if (ch) t2 <= 1; else t1 <= 1;
		@(posedge clk);
		{t1, t2} <= 2'b00;
		repeat (4) @(posedge clk);
	endtask
	task rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
		acc(0, a, 0);
		chk(nm, q, exp);
	endtask
	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		foreach (rows[i]) begin
			acc(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("rdata", q, rows[i].q);
			chk("err", e, rows[i].e);
		end
		@(posedge clk) axis <= 32'h8000_1234;
		acc(1, 'ha08, 1);
		flip(0);
		rdc("pos1 hi", 'ha0c, 'h8000);
		rdc("pos1 lo", 'ha0d, 'h1234);
		rdc("count1", 'ha10, 1);
		rdc("arm1", 'ha08, 0);
		@(posedge clk) axis <= 5;
		flip(0);
		flip(0);
		rdc("pos1 held", 'ha0d, 'h1234);
		acc(1, 'ha08, 2);
		rdc("count1 clr", 'ha10, 0);
		@(posedge clk) axis <= 7;
		repeat (4) flip(0);
		rdc("count1 cont", 'ha10, 2);
		rdc("arm1 cont", 'ha08, 2);
		@(posedge clk) shift <= 16;
		@(posedge clk) redef <= 1;
		@(posedge clk) redef <= 0;
		rdc("pos1 shift", 'ha0d, 23);
		acc(1, 'ha08, 0);
		repeat (2) flip(0);
		rdc("count1 stop", 'ha10, 2);
		acc(1, 'ha06, 0);
		acc(1, 'ha0a, 1);
		@(posedge clk) axis <= 9;
		repeat (2) flip(1);
		rdc("pos2 lo", 'ha0f, 9);
		rdc("count2", 'ha12, 1);
		rdc("flags", 'ha02, 3);
		// mid-run reset returns every field to its reset value
		@(posedge clk) reset <= 1;
		repeat (3) @(posedge clk);
		reset <= 0;
		rdc("flags rst", 'ha02, 0);
		rdc("edge1 rst", 'ha04, 0);
		rdc("count2 rst", 'ha12, 0);
		rdc("pos1 rst", 'ha0d, 0);
		end_sim();
	end
endmodule
